// ### rtl/gio_defs.vh
`ifndef GIO_DEFS_VH
`define GIO_DEFS_VH

// register word select inside one port window
`define GIO_REG_DIR     2'h0
`define GIO_REG_DATA    2'h1
`define GIO_REG_PINS    2'h2
`define GIO_REG_IBUF    2'h3

// address field positions
`define GIO_ADDR_W      12
`define GIO_REG_LSB     2
`define GIO_PORT_LSB    4
`define GIO_PORT_MSB    7
`define GIO_HI_LSB      8
`define GIO_HI_MSB      11

// port count and per-port bit masks, index 0..10 = 1,2,3,4,5,6,A,D,H,J,K
`define GIO_NPORTS      11
`define GIO_MASK_FULL   8'hFF
`define GIO_MASK_P2     8'h0F
`define GIO_MASK_P6     8'h7F
`define GIO_MASK_PA     8'hFE
`define GIO_IDX_P2      1
`define GIO_IDX_P4      3
`define GIO_IDX_P5      4
`define GIO_IDX_P6      5
`define GIO_IDX_PA      6

// reset values
`define GIO_DIR_RST     8'h00
`define GIO_DATA_RST    8'h00
`define GIO_IBUF_RST    8'h00
// value returned by a direction read
`define GIO_DIR_RDVAL   8'h00

`endif

// ### rtl/gio_sync2.v
`timescale 1ns/1ps
module gio_sync2 #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire         ce,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;

  // two-stage capture; meta_q is read only by stab_q
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      meta_q <= {W{1'b0}};
      stab_q <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_q <= asyncIn;
      stab_q <= meta_q;
    end
  end

  assign syncOut = stab_q;

endmodule

// ### rtl/gio_port_regs.v
`timescale 1ns/1ps
`include "gio_defs.vh"
module gio_port_regs #(
  parameter [7:0] MASK   = 8'hFF,
  parameter       HASDIR = 1
) (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       wrDir,
  input  wire       wrData,
  input  wire       wrIbuf,
  input  wire [7:0] wdata,
  input  wire [7:0] pinLvl,
  output wire [7:0] dataOut,
  output wire [7:0] ibufOut,
  output wire [7:0] readback,
  output wire [7:0] periphIn,
  output wire [7:0] pinOut,
  output wire [7:0] pinOutEnN
);

  reg [7:0] dir_q;
  reg [7:0] data_q;
  reg [7:0] ibuf_q;

  // reserved bits never store, so they always read as reset value
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      dir_q  <= `GIO_DIR_RST;
      data_q <= `GIO_DATA_RST;
      ibuf_q <= `GIO_IBUF_RST;
    end
    else if (ce)
    begin
      if (wrDir && (HASDIR != 0))
        dir_q <= wdata & MASK;
      if (wrData && (HASDIR != 0))
        data_q <= wdata & MASK;
      if (wrIbuf)
        ibuf_q <= wdata & MASK;
    end
  end

  assign dataOut   = data_q;
  assign ibufOut   = ibuf_q;
  // driver enabled only for output bits; enable is active low
  assign pinOutEnN = ~dir_q;
  assign pinOut    = data_q;
  // readback has no storage of its own: output bits show the data register, input bits the pins
  assign readback  = ((dir_q & data_q) | (~dir_q & pinLvl)) & MASK;
  // disabled input buffer holds the on-chip input high
  assign periphIn  = (pinLvl & MASK) | ~ibuf_q;

endmodule

// ### rtl/gio_core.v
`timescale 1ns/1ps
`include "gio_defs.vh"
module gio_core #(
  parameter NP = `GIO_NPORTS
) (
  input  wire                   mclk,
  input  wire                   nrst,
  input  wire                   ce,
  input  wire [`GIO_ADDR_W-1:0] paddr,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire [8*NP-1:0]        pinIn,
  output wire [8*NP-1:0]        pinOut,
  output wire [8*NP-1:0]        pinOutEnN,
  output wire [8*NP-1:0]        periphIn
);

  // per-port valid bit mask
  function [7:0] portMask;
    input integer idx;
    begin
      if (idx == `GIO_IDX_P2)
        portMask = `GIO_MASK_P2;
      else if (idx == `GIO_IDX_P6)
        portMask = `GIO_MASK_P6;
      else if (idx == `GIO_IDX_PA)
        portMask = `GIO_MASK_PA;
      else
        portMask = `GIO_MASK_FULL;
    end
  endfunction

  // input-only ports carry no direction or data register
  function portHasDir;
    input integer idx;
    begin
      portHasDir = !((idx == `GIO_IDX_P4) || (idx == `GIO_IDX_P5));
    end
  endfunction

  wire [8*NP-1:0] pinSync;
  wire [8*NP-1:0] dataAll;
  wire [8*NP-1:0] ibufAll;
  wire [8*NP-1:0] readAll;
  wire [NP-1:0]   hasDirAll;

  reg  [31:0]     prdata_q;
  reg             pslverr_q;
  reg             armed_q;
  reg  [31:0]     prdata_d;
  reg             pslverr_d;

  // address fields
  wire [3:0] portSel = paddr[`GIO_PORT_MSB:`GIO_PORT_LSB];
  wire [1:0] regSel  = paddr[`GIO_REG_LSB+1:`GIO_REG_LSB];
  wire [3:0] hiBits  = paddr[`GIO_HI_MSB:`GIO_HI_LSB];
  wire       portOk  = (hiBits == 4'h0) && (portSel < NP);

  // write only at the completing edge; byte lane 0 carries the data
  wire accessWr = psel && penable && pwrite && pready && pstrb[0];

  // pins come from the board, so they are synchronised first
  gio_sync2 #(
    .W (8*NP)
  ) uSync (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1)
    begin : gPort
      wire hit = portOk && (portSel == gi);
      assign hasDirAll[gi] = portHasDir(gi);
      gio_port_regs #(
        .MASK   (portMask(gi)),
        .HASDIR (portHasDir(gi) ? 1 : 0)
      ) uRegs (
        .mclk      (mclk),
        .nrst      (nrst),
        .ce        (ce),
        .wrDir     (accessWr && hit && (regSel == `GIO_REG_DIR)),
        .wrData    (accessWr && hit && (regSel == `GIO_REG_DATA)),
        .wrIbuf    (accessWr && hit && (regSel == `GIO_REG_IBUF)),
        .wdata     (pwdata[7:0]),
        .pinLvl    (pinSync[8*gi+:8]),
        .dataOut   (dataAll[8*gi+:8]),
        .ibufOut   (ibufAll[8*gi+:8]),
        .readback  (readAll[8*gi+:8]),
        .periphIn  (periphIn[8*gi+:8]),
        .pinOut    (pinOut[8*gi+:8]),
        .pinOutEnN (pinOutEnN[8*gi+:8])
      );
    end
  endgenerate

  // selected port's slices for the read mux
  wire [3:0] pIdx    = portOk ? portSel : 4'h0;
  wire [7:0] selData = dataAll[8*pIdx+:8];
  wire [7:0] selIbuf = ibufAll[8*pIdx+:8];
  wire [7:0] selRead = readAll[8*pIdx+:8];
  wire       selDir  = hasDirAll[pIdx];

  // read data and error decided in the setup cycle, one cycle early
  always @*
  begin
    prdata_d  = 32'h00000000;
    pslverr_d = 1'b0;
    if (!portOk)
      pslverr_d = 1'b1;
    else
    begin
      case (regSel)
        `GIO_REG_DIR:
        begin
          // stored setting is never returned
          prdata_d  = {24'h000000, `GIO_DIR_RDVAL};
          pslverr_d = !selDir;
        end
        `GIO_REG_DATA:
        begin
          prdata_d  = selDir ? {24'h000000, selData} : 32'h00000000;
          pslverr_d = !selDir;
        end
        `GIO_REG_PINS:
          prdata_d  = {24'h000000, selRead};
        `GIO_REG_IBUF:
          prdata_d  = {24'h000000, selIbuf};
        default:
          pslverr_d = 1'b1;
      endcase
    end
  end

  // answer registered so bus data comes from flops
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (ce && psel && !armed_q)
    begin
      prdata_q  <= pwrite ? 32'h00000000 : prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // armed once the answer sits in the flops; a setup edge lost to a
  // low clock enable costs one wait state instead of stale read data
  always @(posedge mclk)
  begin
    if (!nrst)
      armed_q <= 1'b0;
    else if (ce && psel)
      armed_q <= !armed_q;
  end

  // zero wait states while the clock enable stays high
  assign pready  = ce && armed_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

endmodule

// ### testbench/gio_core_chk.sv
`timescale 1ns/1ps
module gio_core_chk #(
  parameter NP = 11
) (
  input wire            mclk,
  input wire            nrst,
  input wire            ce,
  input wire [11:0]     paddr,
  input wire            psel,
  input wire            penable,
  input wire            pready,
  input wire            pwrite,
  input wire [31:0]     pwdata,
  input wire [3:0]      pstrb,
  input wire [31:0]     prdata,
  input wire [8*NP-1:0] pinOut,
  input wire [8*NP-1:0] pinOutEnN
);
  // qualified bus strobes
  wire wrHit = psel && penable && pwrite && pready && pstrb[0];
  wire rdSet = psel && !penable && !pwrite && ce;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // reset itself is the cause here, so it may not disable this one
  rst_clear_a: assert property (disable iff (1'b0)
    !nrst |=> &pinOutEnN && pinOut == '0) else $error("reset state");
  dir_write_a: assert property (
    wrHit && paddr == 12'h000 |=> pinOutEnN[7:0] == ~$past(pwdata[7:0]))
    else $error("direction write");
  data_write_a: assert property (
    wrHit && paddr == 12'h004 |=> pinOut[7:0] == $past(pwdata[7:0]))
    else $error("data write");
  ro_write_a: assert property (
    wrHit && paddr[3:2] == 2'h2 |=> $stable(pinOut) && $stable(pinOutEnN))
    else $error("readback write");
  resv_bits_a: assert property (
    pinOut[15:12] == 4'h0 && &pinOutEnN[15:12] && !pinOut[47] &&
    pinOutEnN[47] && !pinOut[48] && pinOutEnN[48]) else $error("reserved");
  absent_pins_a: assert property (
    pinOut[39:24] == 16'h0000 && &pinOutEnN[39:24]) else $error("absent");
  dir_read_a: assert property (
    rdSet && paddr[3:2] == 2'h0 |=> prdata == 32'h00000000)
    else $error("direction read");
  // only output bits are exact, inputs lag through the synchroniser
  mux_read_a: assert property (
    rdSet && paddr[11:2] == 10'h002 |=> (prdata[7:0] & ~pinOutEnN[7:0])
    == (pinOut[7:0] & ~pinOutEnN[7:0])) else $error("readback mux");
endmodule

// ### testbench/gio_pins.sv
`timescale 1ns/1ps
module gio_pins (
  input  wire  [87:0] pinOut,
  input  wire  [87:0] pinOutEnN,
  input  wire  [87:0] boardLvl,
  output logic [87:0] pinIn
);
  // a driven pin shows its own data, an input pin the board level
  assign pinIn = (pinOut & ~pinOutEnN) | (boardLvl & pinOutEnN);
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        mclk, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  rv;
  logic [87:0] pinIn, pinOut, pinOutEnN, periphIn, boardLvl;
  integer      num_errors, num_checks, i;
  localparam [35:0] RB = {12'h010, 12'h050, 12'h060};
  localparam [23:0] RM = {8'h0F, 8'h7F, 8'hFE};
  // design with its pins looped through the board model
  gio_core uut (.mclk(mclk), .nrst(nrst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .periphIn(periphIn));
  gio_pins pins (.pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .boardLvl(boardLvl), .pinIn(pinIn));
  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input [87:0] s, input [87:0] x, input string nm);
    num_checks = num_checks + 1;
    if (s !== x)
    begin
      num_errors = num_errors + 1;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one apb transfer; data and error taken at the ready edge
  task xfer(input [11:0] a, input w, input [7:0] d);
    integer n;
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge mclk);
    end
    if (pready !== 1'b1)
    begin
      num_errors = num_errors + 1;
      $display("unexpected pready expected 1 seen %b", pready);
      conclude;
    end
    rv = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task t_reset;
    ck(pinOutEnN, {88{1'b1}}, "dirReset");
    ck(periphIn, {88{1'b1}}, "ibufReset");
    xfer(12'h0A4, 1'b0, 8'h00);
    ck(rv, 8'h00, "dataReset");
    xfer(12'h038, 1'b0, 8'h00);
    ck(rv, 8'h5A, "inputRead");
    $display("reset test done");
  endtask
  task t_port0;
    xfer(12'h000, 1'b1, 8'hF0);
    xfer(12'h004, 1'b1, 8'hA5);
    ck(pinOutEnN[7:0], 8'h0F, "dirEnable");
    ck(pinOut[7:0], 8'hA5, "dataPins");
    xfer(12'h008, 1'b1, 8'hFF);
    xfer(12'h008, 1'b0, 8'h00);
    ck(rv, 8'hAC, "readback");
    xfer(12'h000, 1'b0, 8'h00);
    ck(rv, 8'h00, "dirRead");
    xfer(12'h00C, 1'b1, 8'hFF);
    ck(periphIn[7:0], 8'hAC, "periphOn");
    xfer(12'h00C, 1'b1, 8'h00);
    ck(periphIn[7:0], 8'hFF, "periphOff");
    // read straight after a data write: output bits must not lag pins
    xfer(12'h004, 1'b1, 8'h5A);
    xfer(12'h008, 1'b0, 8'h00);
    ck(rv, 8'h5C, "readbackFresh");
    $display("port0 test done");
  endtask
  // lane 0 strobe off, then clock enable low across a read setup edge
  task t_gate;
    @(posedge mclk);
    pstrb <= 4'hE;
    xfer(12'h004, 1'b1, 8'h00);
    ck(pinOut[7:0], 8'h5A, "strobeOff");
    @(posedge mclk);
    pstrb <= 4'hF;
    fork
      xfer(12'h004, 1'b0, 8'h00);
      begin
        @(posedge mclk);
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    ck(rv, 8'h5A, "gatedRead");
    $display("gate test done");
  endtask
  // ports 2, 6 and A, reserved bits written at their initial value
  task t_resv;
    logic [11:0] b;
    logic [7:0]  m;
    for (i = 0; i < 3; i = i + 1)
    begin
      b = RB[35-12*i -: 12];
      m = RM[23-8*i -: 8];
      xfer(b, 1'b1, m);
      xfer(b + 12'h004, 1'b1, m);
      xfer(b + 12'h008, 1'b0, 8'h00);
      ck(rv, m, "resvPins");
    end
    $display("reserved test done");
  endtask
  task t_err;
    xfer(12'h044, 1'b1, 8'hFF);
    ck(er, 1'b1, "absentWrite");
    xfer(12'h030, 1'b0, 8'h00);
    ck(er, 1'b1, "absentDir");
    $display("absent test done");
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    ce = 1'b1;
    nrst = 1'b0;
    boardLvl = {{10{8'h5A}}, 8'h3C};
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset;
    t_port0;
    t_gate;
    t_resv;
    t_err;
    conclude;
  end
endmodule
bind gio_core gio_core_chk #(.NP(NP)) chk (.mclk(mclk), .nrst(nrst),
  .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pinOut(pinOut), .pinOutEnN(pinOutEnN));
